// ===== hdl/alpm_ctrl.sv
// alpm_ctrl.sv: power-mode sequencer of a sampling converter
// assumes register writes arrive as one-cycle strobes from the serial decoder on clk
// and the conversion pin arrives raw from outside
`timescale 1ns/1ps
`default_nettype none
`include "alpm_defines.svh"
module alpm_ctrl #(
  parameter int LIGHT_WAKE_NS = `ALPM_LIGHT_WAKE_NS,
  parameter int DEEP_WAKE_NS  = `ALPM_DEEP_WAKE_NS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register write strobe from the serial decoder
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  // conversion pin
  input  wire logic       conversion_start_select,
  // status
  output logic            ready_indicator,
  output logic            analog_power_on,
  output logic            light_sleep_mode,
  output logic            deep_power_down_mode,
  output logic            converting,
  output logic            light_sleep_enable,
  output logic            deep_sleep_request,
  output logic            unlocked
);
  function automatic logic [15:0] ns_to_cycles(input int ns);
    int c;
    c = (ns + `ALPM_CLK_PERIOD_NS - 1) / `ALPM_CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return c[15:0];
  endfunction

  localparam logic [15:0] LIGHT_WAKE_CYC = ns_to_cycles(LIGHT_WAKE_NS);
  localparam logic [15:0] DEEP_WAKE_CYC  = ns_to_cycles(DEEP_WAKE_NS);

  alpm_pkg::alpm_state_e state_q;
  alpm_pkg::alpm_state_e state_d;

  logic       pin_lvl;
  logic       pin_rise;
  logic       pin_fall;
  logic       unlock_q;
  logic [1:0] pwrctl_q;
  logic       ready_q;
  logic       analog_q;
  logic       tmr_load;
  logic [15:0] tmr_count;
  logic       tmr_busy;
  logic       tmr_done;
  logic [15:0] conv_q;
  logic       conv_end;

  alpm_sync u_sync (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (conversion_start_select),
    .level_out (pin_lvl),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  alpm_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (tmr_load),
    .count (tmr_count),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  wire key_wr    = reg_wr & (reg_addr == `ALPM_UNLOCK_ADDR) & (reg_wdata == `ALPM_UNLOCK_KEY);
  wire ctl_wr    = reg_wr & (reg_addr == `ALPM_PWRCTL_ADDR) & unlock_q;
  wire ctl_reject = reg_wr & (reg_addr == `ALPM_PWRCTL_ADDR) & ~unlock_q;
  wire ls_en     = pwrctl_q[`ALPM_BIT_LIGHT_SLEEP];
  wire ds_req    = pwrctl_q[`ALPM_BIT_DEEP_SLEEP];
  wire ds_clear  = ctl_wr & ~reg_wdata[`ALPM_BIT_DEEP_SLEEP];
  assign conv_end = (state_q == alpm_pkg::ALPM_CONVERT) & (conv_q == 16'h0001);

  // unlock is one-shot: a control write spends it so a stray write later is refused
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_q <= 1'b0;
      pwrctl_q <= `ALPM_PWRCTL_RESET;
    end else begin
      unlock_q <= key_wr | (unlock_q & ~ctl_wr);
      if (ctl_wr) begin
        pwrctl_q <= {reg_wdata[`ALPM_BIT_DEEP_SLEEP], reg_wdata[`ALPM_BIT_LIGHT_SLEEP]};
      end
    end
  end

  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_count = LIGHT_WAKE_CYC;
    unique case (state_q)
      alpm_pkg::ALPM_NORMAL: begin
        if (pin_rise && ds_req) begin
          state_d = alpm_pkg::ALPM_DEEP_DOWN;
        end else if (pin_rise) begin
          state_d = alpm_pkg::ALPM_CONVERT;
        end
      end
      alpm_pkg::ALPM_CONVERT: begin
        if (conv_end) begin
          state_d = (ls_en && pin_lvl) ? alpm_pkg::ALPM_LIGHT_SLEEP : alpm_pkg::ALPM_NORMAL;
        end
      end
      alpm_pkg::ALPM_LIGHT_SLEEP: begin
        if (pin_fall) begin
          state_d   = alpm_pkg::ALPM_LIGHT_WAKE;
          tmr_load  = 1'b1;
          tmr_count = LIGHT_WAKE_CYC;
        end
      end
      alpm_pkg::ALPM_LIGHT_WAKE: begin
        if (tmr_done) begin
          state_d = alpm_pkg::ALPM_NORMAL;
        end
      end
      alpm_pkg::ALPM_DEEP_DOWN: begin
        if (ds_clear) begin
          state_d   = alpm_pkg::ALPM_DEEP_WAKE;
          tmr_load  = 1'b1;
          tmr_count = DEEP_WAKE_CYC;
        end
      end
      alpm_pkg::ALPM_DEEP_WAKE: begin
        if (tmr_done) begin
          state_d = alpm_pkg::ALPM_NORMAL;
        end
      end
      default: state_d = alpm_pkg::ALPM_NORMAL;
    endcase
  end

  // analog supply off only in deep power-down; light sleep only idles blocks
  wire analog_d = (state_d != alpm_pkg::ALPM_DEEP_DOWN);
  // ready high in deep sleep and from the start of power-up, low while converting or waking from light sleep
  wire ready_d  = (state_d == alpm_pkg::ALPM_DEEP_DOWN) | (state_d == alpm_pkg::ALPM_DEEP_WAKE) |
                  (state_d == alpm_pkg::ALPM_NORMAL) | (state_d == alpm_pkg::ALPM_LIGHT_SLEEP);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= alpm_pkg::ALPM_NORMAL;
      conv_q   <= 16'h0000;
      ready_q  <= 1'b1;
      analog_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      conv_q   <= (state_d == alpm_pkg::ALPM_CONVERT && state_q != alpm_pkg::ALPM_CONVERT) ?
                  `ALPM_CONV_CYCLES : ((conv_q != 16'h0000) ? conv_q - 16'h0001 : conv_q);
      ready_q  <= ready_d;
      analog_q <= analog_d;
    end
  end

  // registered status outputs
  logic ls_mode_q;
  logic pd_mode_q;
  logic conv_out_q;
  logic ls_en_q;
  logic ds_req_q;
  logic unl_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      ls_mode_q  <= 1'b0;
      pd_mode_q  <= 1'b0;
      conv_out_q <= 1'b0;
      ls_en_q    <= 1'b0;
      ds_req_q   <= 1'b0;
      unl_q      <= 1'b0;
    end else begin
      ls_mode_q  <= (state_d == alpm_pkg::ALPM_LIGHT_SLEEP);
      pd_mode_q  <= (state_d == alpm_pkg::ALPM_DEEP_DOWN);
      conv_out_q <= (state_d == alpm_pkg::ALPM_CONVERT);
      ls_en_q    <= ls_en;
      ds_req_q   <= ds_req;
      unl_q      <= unlock_q;
    end
  end

  assign ready_indicator      = ready_q;
  assign analog_power_on      = analog_q;
  assign light_sleep_mode     = ls_mode_q;
  assign deep_power_down_mode = pd_mode_q;
  assign converting           = conv_out_q;
  assign light_sleep_enable   = ls_en_q;
  assign deep_sleep_request   = ds_req_q;
  assign unlocked             = unl_q;

  // assertions
  AST_LOCKED_WRITE: assert property (@(posedge clk) disable iff (rst)
    ctl_reject |=> $stable(pwrctl_q)) else $error("control changed without unlock");
  AST_KEY_UNLOCKS: assert property (@(posedge clk) disable iff (rst)
    key_wr |=> unlock_q) else $error("key write did not unlock");
  AST_NAP_ENTRY: assert property (@(posedge clk) disable iff (rst)
    conv_end && ls_en && pin_lvl |=> state_q == alpm_pkg::ALPM_LIGHT_SLEEP) else $error("light sleep not entered");
  AST_NAP_HOLD: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_LIGHT_SLEEP && !pin_fall |=> state_q == alpm_pkg::ALPM_LIGHT_SLEEP)
    else $error("light sleep left early");
  AST_NAP_EXIT: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_LIGHT_SLEEP && pin_fall |=> state_q == alpm_pkg::ALPM_LIGHT_WAKE)
    else $error("light sleep not left on falling edge");
  AST_PD_ENTRY: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_NORMAL && pin_rise && ds_req |=> ##1 !analog_power_on && deep_power_down_mode)
    else $error("deep power-down not entered");
  AST_PD_READY: assert property (@(posedge clk) disable iff (rst)
    deep_power_down_mode |-> ready_indicator) else $error("ready low in deep power-down");
  AST_PD_KEEP_REGS: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_DEEP_DOWN && !ctl_wr |=> $stable(pwrctl_q)) else $error("register lost in power-down");
  AST_PD_EXIT: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_DEEP_DOWN && ds_clear |=> ##1 analog_power_on && ready_indicator)
    else $error("power-up not started");
  AST_NORMAL_POWERED: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_NORMAL |-> analog_power_on) else $error("analog off in normal mode");

  // a control write spends the key, so a second change needs a fresh unlock
  AST_UNLOCK_SPENT: assert property (@(posedge clk) disable iff (rst)
    ctl_wr |=> !unlock_q) else $error("unlock not spent by control write");
  // without both enable and a high pin the conversion ends in normal mode
  AST_NAP_SKIP: assert property (@(posedge clk) disable iff (rst)
    conv_end && !(ls_en && pin_lvl) |=> state_q == alpm_pkg::ALPM_NORMAL)
    else $error("light sleep entered without cause");
  // light sleep only idles blocks, the analog supply stays up
  AST_NAP_POWERED: assert property (@(posedge clk) disable iff (rst)
    light_sleep_mode |-> analog_power_on) else $error("analog off in light sleep");
  // the request alone does nothing until the pin rises
  AST_PD_EDGE_ONLY: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_NORMAL && ds_req && !pin_rise |=> state_q != alpm_pkg::ALPM_DEEP_DOWN)
    else $error("deep power-down entered without pin edge");
  AST_PD_NO_CONV: assert property (@(posedge clk) disable iff (rst)
    deep_power_down_mode |-> !converting) else $error("conversion during deep power-down");
  AST_BITS_COPIED: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> light_sleep_enable == $past(ls_en) && deep_sleep_request == $past(ds_req))
    else $error("control bits not kept on outputs");
  AST_PD_WAKE_READY: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_DEEP_WAKE |-> ready_indicator && analog_power_on)
    else $error("ready or power low during power-up");
  // a conversion in flight is never reported ready
  AST_CONV_BUSY: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_CONVERT |-> !ready_indicator) else $error("ready high while converting");
  // the wake states must always have the timer running or just expired
  AST_LIGHT_TIMER: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_LIGHT_WAKE |-> tmr_busy || tmr_done) else $error("light wake timer idle");
  AST_DEEP_TIMER: assert property (@(posedge clk) disable iff (rst)
    state_q == alpm_pkg::ALPM_DEEP_WAKE |-> tmr_busy || tmr_done) else $error("deep wake timer idle");

  COV_NAP: cover property (@(posedge clk) disable iff (rst) state_q == alpm_pkg::ALPM_LIGHT_WAKE && tmr_done);
  COV_NAP_ENTRY: cover property (@(posedge clk) disable iff (rst) conv_end && ls_en && pin_lvl);
  COV_PD_ENTRY: cover property (@(posedge clk) disable iff (rst) state_q == alpm_pkg::ALPM_NORMAL && pin_rise && ds_req);
  COV_PD: cover property (@(posedge clk) disable iff (rst) state_q == alpm_pkg::ALPM_DEEP_WAKE && tmr_done);
  COV_REJECT: cover property (@(posedge clk) disable iff (rst) ctl_reject);
endmodule
`default_nettype wire

// ===== hdl/alpm_defines.svh
// alpm_defines.svh: constants of the converter power-mode control
// assumes inclusion by bare name from the design files
`ifndef ALPM_DEFINES_SVH
`define ALPM_DEFINES_SVH

`define ALPM_UNLOCK_ADDR      8'h05
`define ALPM_UNLOCK_KEY       8'h69
`define ALPM_PWRCTL_ADDR      8'h04
`define ALPM_BIT_LIGHT_SLEEP  0
`define ALPM_BIT_DEEP_SLEEP   1
`define ALPM_PWRCTL_RESET     2'h0
`define ALPM_CLK_PERIOD_NS    25
`define ALPM_LIGHT_WAKE_NS    4000
`define ALPM_DEEP_WAKE_NS     20000
`define ALPM_CONV_CYCLES      16'h0020

`endif

// ===== hdl/alpm_pkg.sv
// alpm_pkg.sv: types of the converter power-mode control
// assumes nothing beyond a SystemVerilog compiler
package alpm_pkg;
  typedef enum logic [2:0] {
    ALPM_NORMAL,
    ALPM_CONVERT,
    ALPM_LIGHT_SLEEP,
    ALPM_LIGHT_WAKE,
    ALPM_DEEP_DOWN,
    ALPM_DEEP_WAKE
  } alpm_state_e;
endpackage

// ===== hdl/alpm_sync.sv
// alpm_sync.sv: two-flop synchroniser with edge outputs taken after the second flop
// assumes a pin input asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module alpm_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and result
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~last_q;
  assign fall_out  = ~sync_q & last_q;
endmodule
`default_nettype wire

// ===== hdl/alpm_timer.sv
// alpm_timer.sv: one-shot down counter for wake times
// assumes load is a one-cycle pulse on clk
`timescale 1ns/1ps
`default_nettype none
module alpm_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        load,
  input  wire logic [15:0] count,
  // status
  output logic             busy,
  output logic             done
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        done_q;

  assign cnt_d = load ? count : ((cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= ~load & (cnt_q == 16'h0001);
    end
  end

  assign busy = (cnt_q != 16'h0000);
  assign done = done_q;
endmodule
`default_nettype wire

// ===== verif/adc_low_power_mode_control_test.sv
// adc_low_power_mode_control_test.sv: self-checking bench of alpm_ctrl
// assumes alpm_host_model drives the writes and the pin
`timescale 1ns/1ps
`default_nettype none
`include "alpm_defines.svh"
module adc_low_power_mode_control_test;
  logic       clk;
  logic       rst;
  logic       reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       pin;
  logic       rdy;
  logic       apwr;
  logic       lsm;
  logic       dpd;
  logic       conv;
  logic       lse;
  logic       dsr;
  logic       unl;
  logic [7:0] rnd;
  int         fail_count;
  int         cmp_count;
  int         m_l;
  int         m_d;
  int         m_u;
  localparam int WAKE_NS = 100;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  alpm_host_model #(.LIGHT_WAKE_NS(WAKE_NS), .DEEP_WAKE_NS(WAKE_NS)) host_u (.clk(clk), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pin(pin));
  alpm_ctrl #(.LIGHT_WAKE_NS(WAKE_NS), .DEEP_WAKE_NS(WAKE_NS)) dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .conversion_start_select(pin), .ready_indicator(rdy),
    .analog_power_on(apwr), .light_sleep_mode(lsm), .deep_power_down_mode(dpd), .converting(conv),
    .light_sleep_enable(lse), .deep_sleep_request(dsr), .unlocked(unl));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: return rdy;
      1: return conv;
      2: return lsm;
      3: return dpd;
      default: return apwr;
    endcase
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask
  task automatic wait_for(input int k, input logic v);
    for (int n = 0; n < 300; n++) begin
      @(posedge clk);
      #1;
      if (pick(k) === v) return;
    end
    fail_count++;
    $display("wrong value at %0t: wait %0d timed out", $time, k);
    end_of_test();
  endtask
  // reference model of the key and control bits
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    if (a == `ALPM_UNLOCK_ADDR && d == `ALPM_UNLOCK_KEY) begin
      m_u = 1;
    end else if (a == `ALPM_PWRCTL_ADDR && m_u == 1) begin
      m_l = d[0];
      m_d = d[1];
      m_u = 0;
    end
  endtask
  task automatic ctl_chk();
    repeat (2) @(posedge clk);
    #1;
    chk(lse, m_l[0], "light enable");
    chk(dsr, m_d[0], "deep request");
    chk(unl, m_u[0], "unlock flag");
  endtask
  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    mwr(a, d);
    ctl_chk();
  endtask
  task automatic bul(input logic [7:0] d);
    host_u.unlock_wr(d);
    mwr(`ALPM_UNLOCK_ADDR, `ALPM_UNLOCK_KEY);
    mwr(`ALPM_PWRCTL_ADDR, d);
    ctl_chk();
  endtask
  task automatic pulse_conv();
    host_u.pin_to(1'b1);
    wait_for(1, 1'b1);
    chk(apwr, 1'b1, "power in conversion");
    chk(rdy, 1'b0, "ready in conversion");
    host_u.pin_to(1'b0);
    wait_for(1, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    m_l = 0;
    m_d = 0;
    m_u = 0;
    rnd = 8'h17;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(rdy, 1'b1, "reset ready");
    chk(dpd, 1'b0, "reset deep");
    // locked writes of random data and a wrong key are ignored
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      bwr(i == 3 ? `ALPM_UNLOCK_ADDR : `ALPM_PWRCTL_ADDR, i == 3 ? 8'h68 : rnd);
    end
    $display("test locked done");
    bul(8'h00);
    host_u.pin_to(1'b1);
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    chk(lsm, 1'b0, "sleep while disabled");
    chk(apwr, 1'b1, "power between conversions");
    host_u.pin_to(1'b0);
    bul(8'h01);
    pulse_conv();
    repeat (4) @(posedge clk);
    #1;
    chk(lsm, 1'b0, "sleep with pin low");
    $display("test normal done");
    host_u.pin_to(1'b1);
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    rnd = lfsr(rnd);
    repeat (8 + rnd[4:0]) @(posedge clk);
    #1;
    chk(lsm, 1'b1, "sleep held");
    host_u.pin_to(1'b0);
    wait_for(2, 1'b0);
    host_u.wake_wait(1'b0, rnd[1:0]);
    pulse_conv();
    $display("test light sleep done");
    bul(8'h03);
    repeat (20) @(posedge clk);
    #1;
    chk(dpd, 1'b0, "deep before edge");
    host_u.pin_to(1'b1);
    wait_for(3, 1'b1);
    repeat (30) @(posedge clk);
    #1;
    chk(apwr, 1'b0, "analog off");
    chk(lse, 1'b1, "bits kept");
    chk(rdy, 1'b1, "ready in deep");
    host_u.pin_to(1'b0);
    bul(8'h01);
    chk(rdy, 1'b1, "ready on wake");
    wait_for(4, 1'b1);
    wait_for(3, 1'b0);
    host_u.wake_wait(1'b1, 0);
    pulse_conv();
    $display("test deep done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== verif/alpm_host_model.sv
// alpm_host_model.sv: host controller facing the power-mode control
// assumes the device clock and tasks called from the bench
`timescale 1ns/1ps
`default_nettype none
`include "alpm_defines.svh"
module alpm_host_model #(
  parameter int LIGHT_WAKE_NS = 100,
  parameter int DEEP_WAKE_NS  = 100
) (
  // clock
  input  wire logic       clk,
  // register writes and conversion pin
  output logic            reg_wr,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            pin
);
  initial begin
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    pin       = 1'b0;
  end
  // released lines show the inverse so a stale value cannot pass
  task automatic rel(input logic [7:0] a, input logic [7:0] d);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    rel(a, d);
  endtask
  // key and control on consecutive edges
  task automatic unlock_wr(input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= `ALPM_UNLOCK_ADDR;
    reg_wdata <= `ALPM_UNLOCK_KEY;
    @(posedge clk);
    reg_addr  <= `ALPM_PWRCTL_ADDR;
    reg_wdata <= d;
    @(posedge clk);
    rel(`ALPM_PWRCTL_ADDR, d);
  endtask
  task automatic pin_to(input logic v);
    @(posedge clk);
    pin <= v;
  endtask
  // slack covers the pin synchroniser; extra makes a slow host
  task automatic wake_wait(input logic deep, input int extra);
    repeat ((deep ? DEEP_WAKE_NS : LIGHT_WAKE_NS) / 25 + 4 + extra) @(posedge clk);
  endtask
endmodule
`default_nettype wire
